// File: dv/mbag_addr_gen_monitor.sv
// concurrent checks on the address generator ports
`timescale 1ns/100ps
module mbag_addr_gen_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic accValid,
  input wire logic [2:0] accMode,
  input wire logic [3:0] accPtrSel,
  input wire logic accWrite,
  input wire logic accByte,
  input wire logic [15:0] effectiveAddress,
  input wire logic addrValid,
  input wire logic addrWrite,
  input wire logic addrBitrev,
  input wire logic addrWrapped
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_lat; accValid |-> ##2 addrValid; endproperty
  a_lat: assert property (p_lat)
    else $error("address missing two cycles after request");
  property p_spur; addrValid |-> $past(accValid, 2); endproperty
  a_spur: assert property (p_spur)
    else $error("address without request");
  property p_wr; addrValid |-> addrWrite == $past(accWrite, 2); endproperty
  a_wr: assert property (p_wr)
    else $error("write flag does not follow request");
  property p_mode;
    addrBitrev |-> ($past(accMode, 2) == 3'h1 || $past(accMode, 2) == 3'h3)
      && !$past(accByte, 2) && $past(accWrite, 2);
  endproperty
  a_mode: assert property (p_mode)
    else $error("reversed address on wrong access kind");
  property p_stack; addrValid && $past(accPtrSel, 2) == 4'hF |-> !addrBitrev; endproperty
  a_stack: assert property (p_stack)
    else $error("reversed address through stack pointer");
  property p_lsb; addrBitrev |-> !effectiveAddress[0]; endproperty
  a_lsb: assert property (p_lsb)
    else $error("reversed address not word aligned");
  property p_prec; addrBitrev |-> !addrWrapped; endproperty
  a_prec: assert property (p_prec)
    else $error("modulo applied over reversed address");
  property p_flag; addrBitrev || addrWrapped |-> addrValid; endproperty
  a_flag: assert property (p_flag)
    else $error("flag without address");
endmodule // mbag_addr_gen_monitor
bind mbag_addr_gen mbag_addr_gen_monitor i_mon (.clk(clk), .rst_b(rst_b),
  .accValid(accValid), .accMode(accMode), .accPtrSel(accPtrSel), .accWrite(accWrite),
  .accByte(accByte), .effectiveAddress(effectiveAddress), .addrValid(addrValid),
  .addrWrite(addrWrite), .addrBitrev(addrBitrev), .addrWrapped(addrWrapped));

// File: dv/mbag_mem_model.sv
// data memory bus model that counts write cycles
`timescale 1ns/100ps
module mbag_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic addrValid,
  input wire logic addrWrite,
  output logic [7:0] nWrites
);
  always @(posedge clk) begin
    if (!rst_b) begin
      nWrites <= 8'h00;
    end else if (addrValid && addrWrite) begin
      nWrites <= nWrites + 8'h01;
    end
  end
endmodule // mbag_mem_model

// File: dv/modulo_bitrev_address_gen_tb_top.sv
// self-checking bench for the address generator
`timescale 1ns/100ps
module modulo_bitrev_address_gen_tb_top;
  logic clk, rst_b, regWrite, regRead, accValid, accWrite, accByte, ptrLoad;
  logic [3:0] regAddr, accPtrSel, ptrLoadSel;
  logic [15:0] regWrData, accOffset, ptrLoadData, regRdData, effectiveAddress, rp, ro;
  logic [2:0] accMode;
  logic addrValid, addrWrite, addrBitrev, addrWrapped, pendRd;
  logic [7:0] nWrites, expW;
  logic [17:0] accQ[$];
  logic [15:0] regQ[$];
  int nFail, checks, cyc, i;
  integer seed;
  mbag_addr_gen i_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .accValid(accValid),
    .accMode(accMode), .accPtrSel(accPtrSel), .accOffset(accOffset), .accWrite(accWrite),
    .accByte(accByte), .ptrLoad(ptrLoad), .ptrLoadSel(ptrLoadSel), .ptrLoadData(ptrLoadData),
    .effectiveAddress(effectiveAddress), .addrValid(addrValid), .addrWrite(addrWrite),
    .addrBitrev(addrBitrev), .addrWrapped(addrWrapped));
  mbag_mem_model i_mem (.clk(clk), .rst_b(rst_b), .addrValid(addrValid),
    .addrWrite(addrWrite), .nWrites(nWrites));
  // ****************************************
  // bus tasks and compares
  // ****************************************
  task chkAddr(input logic [17:0] g, input logic [17:0] e);
    checks++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task chkReg(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task chkCount(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a; regWrData <= d; regWrite <= 1'b1;
    @(posedge clk); regWrite <= 1'b0; @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a; regRead <= 1'b1; regQ.push_back(e);
    @(posedge clk); regRead <= 1'b0; @(posedge clk);
  endtask
  task ld(input logic [3:0] s, input logic [15:0] d);
    ptrLoadSel <= s; ptrLoadData <= d; ptrLoad <= 1'b1;
    @(posedge clk); ptrLoad <= 1'b0; @(posedge clk);
  endtask
  // idle cycle after each access keeps same-pointer requests apart
  task acc(input logic [2:0] m, input logic [3:0] s, input logic [15:0] o, input logic w,
    input logic b, input logic [15:0] ea, input logic br, input logic wp);
    accMode <= m; accPtrSel <= s; accOffset <= o; accWrite <= w; accByte <= b;
    accValid <= 1'b1; accQ.push_back({ea, br, wp}); expW = expW + {7'h00, w};
    @(posedge clk); accValid <= 1'b0; @(posedge clk);
  endtask
  task conclude;
    $display("checks=%0d nFail=%0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (addrValid === 1'b1)
      chkAddr({effectiveAddress, addrBitrev, addrWrapped}, accQ.pop_front());
    if (pendRd === 1'b1) chkReg(regRdData, regQ.pop_front());
    pendRd <= regRead;
    if (cyc == 3000) begin
      nFail++;
      conclude();
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_b, regWrite, regRead, accValid, accWrite, accByte, ptrLoad, pendRd} = 8'h00;
    {regAddr, accPtrSel, ptrLoadSel, accMode} = 15'h0000;
    {regWrData, accOffset, ptrLoadData} = 48'h0;
    expW = 8'h00; seed = 6247;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i++) rd(i[3:0], i == 1 ? 16'h00FF : i == 3 ? 16'h0001 : 16'h0000);
    wr(4'h9, 16'hFFFF); rd(4'h9, 16'h0000);
    $display("registers done");
    for (i = 0; i < 3; i++) begin
      rp = 16'($random(seed)); ro = 16'($random(seed));
      ld(4'h5, rp);
      acc(3'h5, 4'h5, ro, 1'b0, 1'b0, rp + ro, 1'b0, 1'b0);
      acc(3'h1, 4'h5, ro, 1'b0, 1'b0, rp, 1'b0, 1'b0);
      acc(3'h0, 4'h5, ro, 1'b0, 1'b0, rp + 16'h0002, 1'b0, 1'b0);
    end
    wr(4'h1, 16'h80F3); wr(4'h2, 16'h0200); wr(4'h3, 16'h0207); ld(4'h3, 16'h0206);
    acc(3'h3, 4'h3, 16'h0000, 1'b0, 1'b0, 16'h0200, 1'b0, 1'b1);
    acc(3'h5, 4'h3, 16'h000A, 1'b0, 1'b0, 16'h0202, 1'b0, 1'b1);
    acc(3'h4, 4'h3, 16'h0000, 1'b0, 1'b0, 16'h0206, 1'b0, 1'b1);
    acc(3'h2, 4'h3, 16'h0000, 1'b0, 1'b0, 16'h0206, 1'b0, 1'b0);
    rd(4'h4, 16'h0003); wr(4'h4, 16'h0000); rd(4'h4, 16'h0000);
    $display("modulo done");
    wr(4'h0, 16'h8002); rd(4'h0, 16'h8002);
    wr(4'h1, 16'h8022); wr(4'h2, 16'h0400); wr(4'h3, 16'h0407); ld(4'h2, 16'h0404);
    acc(3'h1, 4'h2, 16'h0000, 1'b1, 1'b0, 16'h0404, 1'b1, 1'b0);
    acc(3'h1, 4'h2, 16'h0000, 1'b1, 1'b0, 16'h0402, 1'b1, 1'b0);
    acc(3'h3, 4'h2, 16'h0000, 1'b1, 1'b0, 16'h0400, 1'b1, 1'b0);
    acc(3'h3, 4'h2, 16'h0000, 1'b0, 1'b0, 16'h0402, 1'b0, 1'b0);
    acc(3'h3, 4'h2, 16'h0000, 1'b1, 1'b1, 16'h0403, 1'b0, 1'b0);
    acc(3'h2, 4'h2, 16'h0000, 1'b1, 1'b0, 16'h0403, 1'b0, 1'b0);
    wr(4'h1, 16'h80F2); ld(4'hF, 16'h0800);
    acc(3'h1, 4'hF, 16'h0000, 1'b1, 1'b0, 16'h0800, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chkCount(nWrites, expW);
    $display("bit reverse done");
    conclude();
  end
endmodule // modulo_bitrev_address_gen_tb_top

// File: hw/mbag_addr_gen.v
// data-space effective address generator with modulo and bit-reversed correction
`timescale 1ns/100ps
`include "mbag_map.vh"
module mbag_addr_gen #(
  parameter WIDTH = 16,
  parameter SEL_W = 4,
  parameter X_SPACE = 1
) (
  input wire clk,
  input wire rst_b,
  input wire [`MBAG_ADDR_WIDTH-1:0] regAddr,
  input wire [WIDTH-1:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [WIDTH-1:0] regRdData,
  input wire accValid,
  input wire [2:0] accMode,
  input wire [SEL_W-1:0] accPtrSel,
  input wire [WIDTH-1:0] accOffset,
  input wire accWrite,
  input wire accByte,
  input wire ptrLoad,
  input wire [SEL_W-1:0] ptrLoadSel,
  input wire [WIDTH-1:0] ptrLoadData,
  output reg [WIDTH-1:0] effectiveAddress,
  output reg addrValid,
  output reg addrWrite,
  output reg addrBitrev,
  output reg addrWrapped
);

  // ****************************************
  // software registers
  // ****************************************
  reg [WIDTH-1:0] bit_reverse_control;
  reg [WIDTH-1:0] modulo_control_reg;
  reg [WIDTH-1:0] modStart;
  reg [WIDTH-1:0] modEnd;
  reg [WIDTH-1:0] wrapCount;

  wire bitrevEnable = bit_reverse_control[`MBAG_BITREV_EN_BIT];
  wire [WIDTH-2:0] pivotModifier = bit_reverse_control[WIDTH-2:0];
  wire moduloEnable = modulo_control_reg[`MBAG_MOD_XEN_BIT];
  wire [SEL_W-1:0] moduloPtr = modulo_control_reg[`MBAG_MOD_PTR_LSB+SEL_W-1:`MBAG_MOD_PTR_LSB];
  wire [SEL_W-1:0] bitrevPointerSelect =
    modulo_control_reg[`MBAG_PTR_SEL_LSB+SEL_W-1:`MBAG_PTR_SEL_LSB];

  // ****************************************
  // mode decoding
  // ****************************************
  function isModify;
    input [2:0] mode;
    begin
      isModify = (mode == `MBAG_MODE_POST_INC) || (mode == `MBAG_MODE_POST_DEC) ||
        (mode == `MBAG_MODE_PRE_INC) || (mode == `MBAG_MODE_PRE_DEC);
    end
  endfunction

  function isIncrement;
    input [2:0] mode;
    begin
      isIncrement = (mode == `MBAG_MODE_POST_INC) || (mode == `MBAG_MODE_PRE_INC);
    end
  endfunction

  function isPre;
    input [2:0] mode;
    begin
      isPre = (mode == `MBAG_MODE_PRE_INC) || (mode == `MBAG_MODE_PRE_DEC);
    end
  endfunction

  // ****************************************
  // pointer file
  // ****************************************
  // request is registered one cycle so the pointer read data line up with it
  reg stValid;
  reg [2:0] stMode;
  reg [SEL_W-1:0] stSel;
  reg [WIDTH-1:0] stOffset;
  reg stWrite;
  reg stByte;
  wire [WIDTH-1:0] ptrValue;
  reg ptrWe;
  reg [SEL_W-1:0] ptrWeSel;
  reg [WIDTH-1:0] ptrWeData;

  mbag_ptr_file #(
    .WIDTH(WIDTH),
    .SEL_W(SEL_W)
  ) u_ptr (
    .clk(clk),
    .rst_b(rst_b),
    .readSel(accPtrSel),
    .readData(ptrValue),
    .writeEn(ptrWe),
    .writeSel(ptrWeSel),
    .writeData(ptrWeData)
  );

  always @(posedge clk) begin
    if (!rst_b) begin
      stValid <= 1'b0;
      stMode <= `MBAG_MODE_DIRECT;
      stSel <= {SEL_W{1'b0}};
      stOffset <= {WIDTH{1'b0}};
      stWrite <= 1'b0;
      stByte <= 1'b0;
    end else begin
      stValid <= accValid;
      stMode <= accMode;
      stSel <= accPtrSel;
      stOffset <= accOffset;
      stWrite <= accWrite;
      stByte <= accByte;
    end
  end

  // ****************************************
  // address arithmetic
  // ****************************************
  wire [WIDTH-1:0] stepSize = stByte ? {{(WIDTH-1){1'b0}}, 1'b1} : {{(WIDTH-2){1'b0}}, 2'b10};
  wire [WIDTH-1:0] stepped = isIncrement(stMode) ? ptrValue + stepSize : ptrValue - stepSize;
  wire [WIDTH-1:0] offsetAddr = ptrValue + stOffset;
  wire [WIDTH-1:0] bitrevSum;

  mbag_bitrev_add #(
    .WIDTH(WIDTH)
  ) u_brev (
    .pointer(ptrValue),
    .pivot(pivotModifier),
    .sum(bitrevSum)
  );

  // reversed mode: x space, write, word, increment mode, selected non-stack pointer
  wire bitrevActive = (X_SPACE != 0) && bitrevEnable && stWrite && !stByte &&
    isIncrement(stMode) && (bitrevPointerSelect != `MBAG_STACK_SEL) &&
    (stSel == bitrevPointerSelect);
  // modulo applies to any pointer register picked in the control register
  wire moduloActive = moduloEnable && (stSel == moduloPtr) &&
    (isModify(stMode) || stMode == `MBAG_MODE_REG_OFFSET) && !bitrevActive;
  wire [WIDTH-1:0] bufLength = modEnd - modStart + {{(WIDTH-1){1'b0}}, 1'b1};

  reg [WIDTH-1:0] next_ptr;
  reg [WIDTH-1:0] next_ea;
  reg [WIDTH-1:0] rawNew;
  reg [WIDTH-1:0] corrected;
  reg crossed;
  reg countUp;
  always @* begin
    rawNew = (stMode == `MBAG_MODE_REG_OFFSET) ? offsetAddr : stepped;
    countUp = (stMode == `MBAG_MODE_REG_OFFSET) ? !stOffset[WIDTH-1] : isIncrement(stMode);
    crossed = 1'b0;
    corrected = rawNew;
    if (moduloActive) begin
      // greater-than / less-than so steps that jump past the edge still wrap
      if (countUp) begin
        crossed = rawNew > modEnd;
        if (crossed) begin
          corrected = rawNew - bufLength;
        end
      end else begin
        crossed = rawNew < modStart;
        if (crossed) begin
          corrected = rawNew + bufLength;
        end
      end
    end
    if (bitrevActive) begin
      next_ptr = bitrevSum;
    end else begin
      next_ptr = corrected;
    end
    if (stMode == `MBAG_MODE_REG_OFFSET) begin
      next_ea = corrected;
    end else if (isPre(stMode)) begin
      next_ea = next_ptr;
    end else if (bitrevActive) begin
      next_ea = {ptrValue[WIDTH-1:1], 1'b0};
    end else begin
      next_ea = ptrValue;
    end
  end

  // ****************************************
  // write-back and outputs
  // ****************************************
  always @* begin
    ptrWe = 1'b0;
    ptrWeSel = stSel;
    ptrWeData = next_ptr;
    if (stValid && isModify(stMode)) begin
      ptrWe = 1'b1;
    end else if (ptrLoad) begin
      ptrWe = 1'b1;
      ptrWeSel = ptrLoadSel;
      ptrWeData = ptrLoadData;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      effectiveAddress <= {WIDTH{1'b0}};
      addrValid <= 1'b0;
      addrWrite <= 1'b0;
      addrBitrev <= 1'b0;
      addrWrapped <= 1'b0;
    end else begin
      effectiveAddress <= next_ea;
      addrValid <= stValid;
      addrWrite <= stWrite;
      addrBitrev <= stValid && bitrevActive;
      addrWrapped <= stValid && crossed;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  // a pipeline load collides with a modify write-back; the modify wins, load is lost
  always @(posedge clk) begin
    if (!rst_b) begin
      bit_reverse_control <= `MBAG_BITREV_CTRL_RST;
      modulo_control_reg <= `MBAG_MOD_CTRL_RST;
      modStart <= `MBAG_MOD_START_RST;
      modEnd <= `MBAG_MOD_END_RST;
      wrapCount <= {WIDTH{1'b0}};
    end else begin
      if (regWrite && regAddr == `MBAG_ADDR_BITREV_CTRL) begin
        bit_reverse_control <= regWrData;
      end
      if (regWrite && regAddr == `MBAG_ADDR_MOD_CTRL) begin
        modulo_control_reg <= regWrData;
      end
      if (regWrite && regAddr == `MBAG_ADDR_MOD_START) begin
        modStart <= regWrData;
      end
      if (regWrite && regAddr == `MBAG_ADDR_MOD_END) begin
        modEnd <= regWrData;
      end
      // counter increment wins over a software clear in the same cycle
      if (stValid && crossed) begin
        wrapCount <= wrapCount + {{(WIDTH-1){1'b0}}, 1'b1};
      end else if (regWrite && regAddr == `MBAG_ADDR_STATUS) begin
        wrapCount <= {WIDTH{1'b0}};
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      regRdData <= {WIDTH{1'b0}};
    end else if (regRead) begin
      case (regAddr)
        `MBAG_ADDR_BITREV_CTRL: regRdData <= bit_reverse_control;
        `MBAG_ADDR_MOD_CTRL: regRdData <= modulo_control_reg;
        `MBAG_ADDR_MOD_START: regRdData <= modStart;
        `MBAG_ADDR_MOD_END: regRdData <= modEnd;
        `MBAG_ADDR_STATUS: regRdData <= wrapCount;
        default: regRdData <= {WIDTH{1'b0}};
      endcase
    end else begin
      regRdData <= {WIDTH{1'b0}};
    end
  end

endmodule // mbag_addr_gen

// File: hw/mbag_bitrev_add.v
// reversed-carry adder for bit-reversed pointer stepping
`timescale 1ns/100ps
module mbag_bitrev_add #(
  parameter WIDTH = 16
) (
  input wire [WIDTH-1:0] pointer,
  input wire [WIDTH-2:0] pivot,
  output wire [WIDTH-1:0] sum
);
  // the modifier counts as reversed: reverse pointer, add reversed pivot, reverse back
  // lsb is excluded because word data keeps it clear
  wire [WIDTH-2:0] revPtr;
  wire [WIDTH-2:0] revPiv;
  wire [WIDTH-2:0] revSum;
  genvar i;
  generate
    for (i = 0; i < WIDTH-1; i = i + 1) begin : g_rev
      assign revPtr[i] = pointer[WIDTH-1-i];
      assign revPiv[i] = pivot[WIDTH-2-i];
      assign sum[WIDTH-1-i] = revSum[i];
    end
  endgenerate
  assign revSum = revPtr + revPiv;
  assign sum[0] = 1'b0;
endmodule // mbag_bitrev_add

// File: hw/mbag_ptr_file.v
// pointer register file with registered read port
`timescale 1ns/100ps
module mbag_ptr_file #(
  parameter WIDTH = 16,
  parameter SEL_W = 4
) (
  input wire clk,
  input wire rst_b,
  input wire [SEL_W-1:0] readSel,
  output reg [WIDTH-1:0] readData,
  input wire writeEn,
  input wire [SEL_W-1:0] writeSel,
  input wire [WIDTH-1:0] writeData
);
  reg [WIDTH-1:0] mem [0:(1<<SEL_W)-1];
  always @(posedge clk) begin
    if (writeEn) begin
      mem[writeSel] <= writeData;
    end
    if (!rst_b) begin
      readData <= {WIDTH{1'b0}};
    end else if (writeEn && writeSel == readSel) begin
      readData <= writeData;
    end else begin
      readData <= mem[readSel];
    end
  end
endmodule // mbag_ptr_file

// File: include/mbag_map.vh
// register offsets, field positions and reset values of the address correction block
`ifndef MBAG_MAP_VH
`define MBAG_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define MBAG_ADDR_BITREV_CTRL 4'h0
`define MBAG_ADDR_MOD_CTRL 4'h1
`define MBAG_ADDR_MOD_START 4'h2
`define MBAG_ADDR_MOD_END 4'h3
`define MBAG_ADDR_STATUS 4'h4
`define MBAG_ADDR_WIDTH 4

// ****************************************
// field positions and reset values
// ****************************************
`define MBAG_BITREV_EN_BIT 15
`define MBAG_MOD_XEN_BIT 15
`define MBAG_MOD_PTR_LSB 0
`define MBAG_PTR_SEL_LSB 4
`define MBAG_STACK_SEL 4'hF
`define MBAG_BITREV_CTRL_RST 16'h0000
`define MBAG_MOD_CTRL_RST 16'h00FF
`define MBAG_MOD_START_RST 16'h0000
`define MBAG_MOD_END_RST 16'h0001

// ****************************************
// addressing mode codes
// ****************************************
`define MBAG_MODE_DIRECT 3'h0
`define MBAG_MODE_POST_INC 3'h1
`define MBAG_MODE_POST_DEC 3'h2
`define MBAG_MODE_PRE_INC 3'h3
`define MBAG_MODE_PRE_DEC 3'h4
`define MBAG_MODE_REG_OFFSET 3'h5

`endif
